// *** hdl/rbp_pkg.sv ***
`default_nettype none
// Shared constants and carriers for the registered buffer with parity
package rbp_pkg;

	// Width of the chip-select gated command/address word
	localparam int CA_W = 22;
	// Number of chip select inputs
	localparam int CS_W = 2;
	// Words held by the capture trace FIFO
	localparam int FIFO_DEPTH = 16;

	// Cycles between a word and its parity bit
	localparam int PAR_LAG_CYC = 1;
	// Extra cycles before the error reaches the pin
	localparam int ERR_DELAY_CYC = 1;
	// Cycles the error output stays low
	localparam logic [1:0] ERR_HOLD_CYC = 2'h2;

	// Reset values
	localparam logic [CA_W-1:0] CA_RST = 22'h000000;
	localparam logic [CS_W-1:0] CS_RST = 2'h0;
	localparam logic [1:0] HOLD_RST = 2'h0;

	// One captured word with the chip selects seen with it
	typedef struct packed {
		logic [CS_W-1:0] cs;	// Chip selects, active low
		logic [CA_W-1:0] ca;	// Command/address bits
	} rbp_word_s;

	// Width of a FIFO entry
	localparam int WORD_W = CS_W + CA_W;

endpackage
`default_nettype wire

// *** hdl/rbp_fifo.sv ***
`default_nettype none
// Small synchronous FIFO built from flip-flops
module rbp_fifo #(
	parameter int WIDTH = 24,	// Bits per entry
	parameter int DEPTH = 16,	// Number of entries
	localparam int AW = $clog2(DEPTH)
) (
	input  wire logic             mclk_i,      // System clock
	input  wire logic             rst_i,       // Async reset, high
	input  wire logic             in_valid_i,  // Write request
	input  wire logic [WIDTH-1:0] in_data_i,   // Write data
	output logic                  in_ready_o,  // Room for a word
	output logic                  out_valid_o, // Word available
	output logic      [WIDTH-1:0] out_data_o,  // Oldest word
	input  wire logic             out_ready_i  // Reader takes word
);

	// Whole state of the FIFO
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;	// Storage
		logic [AW-1:0]               wp;	// Write index
		logic [AW-1:0]               rp;	// Read index
		logic [AW:0]                 cnt;	// Fill level
	} rbp_fifo_s;

	rbp_fifo_s st;
	rbp_fifo_s next_st;
	logic      push;
	logic      pop;

	// Honest flags straight from the fill level
	assign in_ready_o  = (st.cnt != (AW+1)'(DEPTH));
	assign out_valid_o = (st.cnt != '0);
	assign out_data_o  = st.mem[st.rp];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// Next state: write, read and level update
	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wp] = in_data_i;
			next_st.wp = AW'(st.wp + 1'b1);
		end
		if (pop) begin
			next_st.rp = AW'(st.rp + 1'b1);
		end
		// Level moves only when exactly one side acts
		if (push && !pop) begin
			next_st.cnt = (AW+1)'(st.cnt + 1'b1);
		end else if (pop && !push) begin
			next_st.cnt = (AW+1)'(st.cnt - 1'b1);
		end
	end

	// State register
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule
`default_nettype wire

// *** hdl/rbp_top.sv ***
`default_nettype none
module rbp_top #(
	parameter int FIFO_DEPTH = rbp_pkg::FIFO_DEPTH	// Trace FIFO size
) (
	input  wire logic                      mclk_i,              // Clock
	input  wire logic                      rst_i,               // Reset
	input  wire logic [rbp_pkg::CA_W-1:0]  cmd_addr_in_i,       // Cmd/addr
	input  wire logic                      chip_select_in_0_i,  // CS0 low
	input  wire logic                      chip_select_in_1_i,  // CS1 low
	input  wire logic                      parity_in_i,         // Parity
	input  wire logic                      cs_gate_enable_i,    // Gate en
	output logic      [rbp_pkg::CA_W-1:0]  cmd_addr_out_o,      // Redrive
	output logic      [rbp_pkg::CS_W-1:0]  chip_select_out_o,   // CS out
	output logic                           parity_error_n_o,    // OD level
	output logic                           parity_error_n_oe_o, // OD drive
	output logic                           cmd_ready_o,         // FIFO room
	output logic                           trace_valid_o,       // Word out
	output rbp_pkg::rbp_word_s             trace_data_o,        // Trace
	input  wire logic                      trace_ready_i        // Take word
);
	import rbp_pkg::*;

	// True when at least one chip select is low
	function automatic logic any_cs_low(input logic [CS_W-1:0] cs);
		any_cs_low = (cs != {CS_W{1'b1}});
	endfunction

	// True when exactly one chip select is low
	function automatic logic one_cs_low(input logic [CS_W-1:0] cs);
		one_cs_low = ($countones(~cs) == 1);
	endfunction

	// Whole state of the buffer
	typedef struct packed {
		logic [CA_W-1:0] q;        // Re-driven cmd/addr
		logic [CS_W-1:0] qcs;      // Re-driven chip selects
		logic [CA_W-1:0] prev_ca;  // Word awaiting its parity
		logic            prev_chk; // That word needs a check
		logic            res_err;  // Parity result stage
		logic            dly_err;  // Extra delay stage
		logic [1:0]      hold;     // Cycles left with error low
		logic            drv;      // Error pin driven low
		logic            od_lvl;   // Level put on the pin
		logic            push;     // Word to the trace FIFO
		rbp_word_s       word;     // Word for the trace FIFO
	} rbp_state_s;

	rbp_state_s st;       // Current state
	rbp_state_s next_st;  // Next state

	logic [CS_W-1:0] cs_in;     // Chip selects as a vector
	logic            capture;   // Latch the gated inputs now
	logic            fifo_rdy;  // FIFO accepts a word
	logic            par_fail;  // Parity check failed now

	// Chip selects gathered into one vector
	assign cs_in = {chip_select_in_1_i, chip_select_in_0_i};

	// Gate on: only with a select low; gate off: always
	assign capture = cs_gate_enable_i ? any_cs_low(cs_in)
	                                  : 1'b1;

	// Parity over the held word plus the late parity bit
	// Odd count of ones is an error
	assign par_fail = st.prev_chk
	                  && (^{st.prev_ca, parity_in_i});

	// Next state of the buffer
	always_comb begin
		next_st = st;

		// Gated word latching
		if (capture) begin
			next_st.q = cmd_addr_in_i;
		end

		// Chip selects are re-driven every edge
		next_st.qcs = cs_in;

		// Keep this word until its parity arrives
		next_st.prev_ca  = cmd_addr_in_i;
		next_st.prev_chk = one_cs_low(cs_in);

		// Parity result stage, valid one cycle after the word
		// The controller places the bit one cycle late
		next_st.res_err = par_fail;

		// One more cycle before the pin shows it
		next_st.dly_err = st.res_err;

		// Error hold counter
		if (st.dly_err) begin
			// Fresh error restarts the low window
			next_st.hold = ERR_HOLD_CYC;
			next_st.drv  = 1'b1;
		end else if (st.hold > 2'h1) begin
			// Still inside the low window
			next_st.hold = 2'(st.hold - 1'b1);
			next_st.drv  = 1'b1;
		end else begin
			// Window over, release the pin
			next_st.hold = HOLD_RST;
			next_st.drv  = 1'b0;
		end

		// Open-drain pin only ever pulls low
		next_st.od_lvl = 1'b0;

		// Copy the latched word to the trace FIFO
		next_st.push      = capture && fifo_rdy;
		next_st.word.ca   = cmd_addr_in_i;
		next_st.word.cs   = cs_in;
	end

	// State register, rising edge only, async clear
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			// Latches and error state cleared together
			st          <= '0;
			st.q        <= CA_RST;
			st.qcs      <= CS_RST;
			st.hold     <= HOLD_RST;
			st.drv      <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// Trace FIFO of captured words
	rbp_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk_i      (mclk_i),
		.rst_i       (rst_i),
		.in_valid_i  (st.push),
		.in_data_i   (st.word),
		.in_ready_o  (fifo_rdy),
		.out_valid_o (trace_valid_o),
		.out_data_o  (trace_data_o),
		.out_ready_i (trace_ready_i)
	);

	// Outputs straight from the state register; cmd_ready_o from the FIFO fill level
	assign cmd_addr_out_o      = st.q;
	assign chip_select_out_o   = st.qcs;
	assign parity_error_n_o    = st.od_lvl;
	assign parity_error_n_oe_o = st.drv;
	assign cmd_ready_o         = fifo_rdy;

endmodule
`default_nettype wire

// *** verification/rbp_monitor.sv ***
`default_nettype none
// Checks capture and parity timing at the top ports
module rbp_monitor #(
	parameter int FIFO_DEPTH = 16 // Trace size
) (
	input wire logic mclk_i, // Clock
	input wire logic rst_i, // Reset
	input wire logic [rbp_pkg::CA_W-1:0] cmd_addr_in_i, // Word
	input wire logic chip_select_in_0_i, // Select 0
	input wire logic chip_select_in_1_i, // Select 1
	input wire logic parity_in_i, // Parity
	input wire logic cs_gate_enable_i, // Gate
	input wire logic [rbp_pkg::CA_W-1:0] cmd_addr_out_o, // Redrive
	input wire logic [rbp_pkg::CS_W-1:0] chip_select_out_o, // Sel out
	input wire logic parity_error_n_o, // Pin level
	input wire logic parity_error_n_oe_o, // Pin drive
	input wire logic cmd_ready_o, // Room
	input wire logic trace_valid_o, // Trace
	input wire rbp_pkg::rbp_word_s trace_data_o, // Trace word
	input wire logic trace_ready_i // Pop
);
	timeunit 1ns;
	timeprecision 1ps;
	import rbp_pkg::*;
	logic [CA_W-1:0] ca_q; // Word of last edge
	logic [CS_W-1:0] cs_q; // Selects of last edge
	logic det; // Fault found this edge
	logic oe; // Pin pulled low
	// Keep the word that the parity covers
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			ca_q <= CA_RST;
			cs_q <= 2'h3;
		end else begin
			ca_q <= cmd_addr_in_i;
			cs_q <= {chip_select_in_1_i, chip_select_in_0_i};
		end
	end
	assign det = (^cs_q) && (^ca_q ^ parity_in_i);
	assign oe = parity_error_n_oe_o;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	property p_win; det |-> ##3 oe [*2]; endproperty
	property p_src; $rose(oe) |-> $past(det, 3); endproperty
	property p_end;
		$rose(oe) ##1 oe |=> !oe || $past(det, 3) || $past(det, 4);
	endproperty
	property p_od; parity_error_n_o == 1'b0; endproperty
	property p_hold;
		cs_gate_enable_i && chip_select_in_0_i && chip_select_in_1_i
			|=> $stable(cmd_addr_out_o);
	endproperty
	property p_cap;
		!cs_gate_enable_i || !chip_select_in_0_i || !chip_select_in_1_i
			|=> cmd_addr_out_o == $past(cmd_addr_in_i);
	endproperty
	property p_cs; 1'b1 |=> chip_select_out_o == cs_q; endproperty
	property p_rst;
		disable iff (1'b0) rst_i |-> cmd_addr_out_o == CA_RST
			&& chip_select_out_o == CS_RST && !oe;
	endproperty
	a_win: assert property (p_win)
		else $error("error window short");
	a_src: assert property (p_src)
		else $error("error without cause");
	a_end: assert property (p_end)
		else $error("error held too long");
	a_od: assert property (p_od)
		else $error("pin level not low");
	a_hold: assert property (p_hold)
		else $error("gated word changed");
	a_cap: assert property (p_cap)
		else $error("word not captured");
	a_cs: assert property (p_cs)
		else $error("select out wrong");
	a_rst: assert property (p_rst)
		else $error("reset outputs wrong");
	c_det: cover property (det);
	c_end: cover property ($fell(oe));
	c_full: cover property (!cmd_ready_o);
endmodule
bind rbp_top rbp_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) i_rbp_monitor (
	.mclk_i, .rst_i, .cmd_addr_in_i, .chip_select_in_0_i,
	.chip_select_in_1_i, .parity_in_i, .cs_gate_enable_i,
	.cmd_addr_out_o, .chip_select_out_o, .parity_error_n_o,
	.parity_error_n_oe_o, .cmd_ready_o, .trace_valid_o,
	.trace_data_o, .trace_ready_i);
`default_nettype wire

// *** verification/rbp_ctrl_model.sv ***
`default_nettype none
// Controller side: word, then its parity one cycle later
module rbp_ctrl_model (
	input wire logic mclk_i, // Clock
	input wire logic [rbp_pkg::CA_W-1:0] word_i, // Next word
	input wire logic [1:0] cs_i, // Next selects
	input wire logic bad_i, // Corrupt parity
	output logic [rbp_pkg::CA_W-1:0] ca_o, // Word out
	output logic [1:0] cs_o, // Selects out
	output logic par_o // Parity out
);
	timeunit 1ns;
	timeprecision 1ps;
	import rbp_pkg::*;
	logic bad_q; // Corrupt flag of bus word
	initial begin
		ca_o = CA_RST;
		cs_o = 2'h3;
		par_o = 1'b0;
		bad_q = 1'b0;
	end
	// Launch on falling edge
	always @(negedge mclk_i) begin
		ca_o <= word_i;
		cs_o <= cs_i;
		bad_q <= bad_i;
		par_o <= ^ca_o ^ bad_q;
	end
endmodule
`default_nettype wire

// *** verification/rbp_top_tb.sv ***
`default_nettype none
module rbp_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rbp_pkg::*;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b0;
	logic gate = 1'b1;
	logic t_rdy = 1'b1;
	logic [CA_W-1:0] word = CA_RST;
	logic [1:0] cs = 2'h3;
	logic bad = 1'b0;
	logic [CA_W-1:0] ca, q;
	logic [1:0] csi, qcs;
	logic par, err_n, err_oe, c_rdy, t_vld;
	rbp_word_s t_dat;
	wire err_pin = err_oe ? err_n : 1'b1; // Pull-up
	int miscompares = 0;
	int checked = 0;
	always #12.5 mclk_i = ~mclk_i;
	rbp_ctrl_model i_rbp_ctrl_model (.mclk_i, .word_i(word),
		.cs_i(cs), .bad_i(bad), .ca_o(ca), .cs_o(csi), .par_o(par));
	rbp_top #(.FIFO_DEPTH(16)) i_rbp_top (.mclk_i, .rst_i,
		.cmd_addr_in_i(ca), .chip_select_in_0_i(csi[0]),
		.chip_select_in_1_i(csi[1]), .parity_in_i(par),
		.cs_gate_enable_i(gate), .cmd_addr_out_o(q),
		.chip_select_out_o(qcs), .parity_error_n_o(err_n),
		.parity_error_n_oe_o(err_oe), .cmd_ready_o(c_rdy),
		.trace_valid_o(t_vld), .trace_data_o(t_dat),
		.trace_ready_i(t_rdy));
	task chk(input string nm, input logic [31:0] got, exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task close_out;
		if (miscompares == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task step(input logic [CA_W-1:0] w, input logic [1:0] c, b);
		@(posedge mclk_i);
		word <= w;
		cs <= c;
		bad <= b[0];
	endtask
	task t_capture;
		step(22'h2AAAAA, 2'h2, 1'b0);
		step(22'h155555, 2'h3, 1'b0);
		@(negedge mclk_i);
		chk("cap", {qcs, q}, {2'h2, 22'h2AAAAA});
		@(negedge mclk_i);
		chk("hold", {qcs, q}, {2'h3, 22'h2AAAAA});
		gate = 1'b0;
		@(negedge mclk_i);
		chk("nogate", {qcs, q}, {2'h3, 22'h155555});
	endtask
	task err_run(input logic [1:0] c, input logic b);
		logic e;
		e = ^c && b;
		step(22'h000007, c, b);
		step(CA_RST, 2'h3, 1'b0);
		for (int j = 1; j <= 6; j++) begin
			@(negedge mclk_i);
			chk("pin", err_pin, !(e && (j == 4 || j == 5)));
		end
	endtask
	task t_parity;
		err_run(2'h2, 1'b0);
		err_run(2'h1, 1'b1);
		err_run(2'h2, 1'b1);
		err_run(2'h0, 1'b1);
		step(22'h000007, 2'h1, 1'b1);
		step(CA_RST, 2'h3, 1'b0);
		repeat (4) @(negedge mclk_i);
		chk("pinlow", err_pin, 1'b0);
		rst_i = 1'b1;
		#1;
		chk("rstpin", {err_pin, qcs, q}, {1'b1, 24'h0});
		repeat (3) @(negedge mclk_i);
		rst_i = 1'b0;
	endtask
	task t_trace;
		int n;
		n = 0;
		// Stop ungated captures so only the burst reaches the trace
		gate = 1'b1;
		repeat (4) @(negedge mclk_i);
		chk("empty", t_vld, 1'b0);
		t_rdy = 1'b0;
		for (int i = 0; i < 20; i++)
			step(22'h000100 + 22'(i), 2'h2, 1'b0);
		step(CA_RST, 2'h3, 1'b0);
		@(negedge mclk_i);
		gate = 1'b1;
		chk("full", c_rdy, 1'b0);
		t_rdy = 1'b1;
		for (int k = 0; k < 40; k++) begin
			if (t_vld === 1'b1) begin
				if (n == 0)
					chk("head", t_dat, {2'h2, 22'h000100});
				n++;
			end
			@(negedge mclk_i);
		end
		chk("count", n, 16);
		chk("drained", t_vld, 1'b0);
		chk("room", c_rdy, 1'b1);
	endtask
	// Main sequence
	initial begin
		// Raise reset after time zero so the async clear really fires
		#1;
		rst_i = 1'b1;
		repeat (8) @(negedge mclk_i);
		chk("rst", {q, qcs, err_pin, c_rdy, t_vld}, 27'h6);
		rst_i = 1'b0;
		t_capture;
		t_parity;
		t_trace;
		close_out;
	end
endmodule
`default_nettype wire
